// *** hdl/ibh_top.sv ***
// Source and acceptor handshake engines of the instrument bus port.
`timescale 1ns/1ps
`include "ibh_consts.svh"
// Operation
// - Bits 6:5 01 listen, 10 talk.
// - Extended talker matches two-byte talk address.
// - Extended listener matches two-byte listen address.
// - Every byte uses one full three-wire handshake.
// - Each step waits for the slowest acceptor.
// - Never exceed one megabyte per second.
// - Ready and accepted lines are wired-OR composites.
// - Sender is source, receiver is acceptor.
// - Talk only when addressed and in data mode.
// - Listen only when addressed and in data mode.
// - Source starts with data valid released high.
// - Acceptor starts holding ready and accepted low.
// - Source checks both-high error before placing data.
// - Source waits settling time before marking valid.
// - Valid goes low after settle and ready high.
// - Acceptor drops ready, takes byte, releases accepted.
// - Acceptor pulls accepted low once valid rises.
module ibh_top
  import ibh_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = `IBH_SETTLE_CYC,
  parameter int unsigned BYTE_CYC   = `IBH_BYTE_CYC
)
(
  // Clock and reset.
  input  wire logic       CORE_CLK,
  input  wire logic       SYS_RST,
  // Data lines, open drain, a one bit pulls its line low.
  input  wire logic [7:0] DIO_IN,
  output logic      [7:0] DIO_OUT,
  output logic      [7:0] DIO_OE,
  // Handshake lines, open drain.
  input  wire logic       DAV_IN,
  output logic            DAV_OUT,
  output logic            DAV_OE,
  input  wire logic       NRFD_IN,
  output logic            NRFD_OUT,
  output logic            NRFD_OE,
  input  wire logic       NDAC_IN,
  output logic            NDAC_OUT,
  output logic            NDAC_OE,
  // Attention line, low selects command mode.
  input  wire logic       ATN_N,
  // Own address setup.
  input  wire logic [4:0] MY_ADDR,
  input  wire logic [4:0] MY_SEC,
  input  wire logic       EXT_TALK,
  input  wire logic       EXT_LISTEN,
  // Bytes to send as talker.
  input  wire logic [7:0] TX_DATA,
  input  wire logic       TX_VALID,
  output logic            TX_READY,
  // Bytes received as listener.
  output logic      [7:0] RX_DATA,
  output logic            RX_VALID,
  input  wire logic       RX_READY,
  // Status.
  output logic            TALKER,
  output logic            LISTENER,
  output logic            SRC_ERROR
);

  localparam logic [`IBH_CNT_W-1:0] SETTLE_LAST = `IBH_CNT_W'(SETTLE_CYC - 1);
  localparam logic [`IBH_CNT_W-1:0] BYTE_LAST   = `IBH_CNT_W'(BYTE_CYC - 1);
  localparam logic [`IBH_CNT_W-1:0] SETTLE_MIN  = `IBH_CNT_W'(SETTLE_CYC);
  localparam logic [`IBH_CNT_W-1:0] BYTE_MIN    = `IBH_CNT_W'(BYTE_CYC);

  ibh_lines_type          raw;
  ibh_lines_type          s;
  ibh_src_type            src_state;
  ibh_src_type            next_src;
  ibh_acc_type            acc_state;
  ibh_acc_type            next_acc;
  logic [`IBH_CNT_W-1:0]  settle_cnt;
  logic [`IBH_CNT_W-1:0]  rate_cnt;
  logic [7:0]             tx_byte;
  logic                   talk_addr;
  logic                   listen_addr;
  logic                   cmd_strobe;
  logic [7:0]             cmd_byte;
  logic [`IBH_CNT_W-1:0]  data_age;
  logic [`IBH_CNT_W-1:0]  dav_gap;

  assign raw = '{atn_n: ATN_N, dav: DAV_IN, nrfd: NRFD_IN, ndac: NDAC_IN, dio: DIO_IN};

  // All bus lines cross into the core clock before any decision looks at them.
  ibh_sync #(
    .W   ($bits(ibh_lines_type)),
    .RST (`IBH_LINE_IDLE)
  ) u_sync (
    .clk (CORE_CLK),
    .rst (SYS_RST),
    .d   (raw),
    .q   (s)
  );

  ibh_addr u_addr (
    .clk         (CORE_CLK),
    .rst         (SYS_RST),
    .cmd_strobe  (cmd_strobe),
    .cmd_byte    (cmd_byte),
    .my_addr     (MY_ADDR),
    .my_sec      (MY_SEC),
    .ext_talk    (EXT_TALK),
    .ext_listen  (EXT_LISTEN),
    .talk_addr   (talk_addr),
    .listen_addr (listen_addr)
  );

  // Role selection; every device accepts in command mode.
  wire cmd_mode   = !s.atn_n;
  wire talker     = talk_addr && !cmd_mode;
  wire listener   = listen_addr && !cmd_mode;
  wire acc_active = cmd_mode || listener;
  wire dav_valid  = !s.dav;
  wire bus_error  = s.nrfd && s.ndac;
  wire can_take   = cmd_mode || !RX_VALID;
  wire src_start  = (src_state == SRC_IDLE) && talker && TX_VALID && !bus_error;
  wire take_now   = (acc_state == ACC_READY) && dav_valid;

  assign TALKER   = talker;
  assign LISTENER = listener;

  // Lines are only ever pulled low, so several acceptors combine as wired-OR.
  assign DIO_OUT  = 8'h00;
  assign DAV_OUT  = 1'h0;
  assign NRFD_OUT = 1'h0;
  assign NDAC_OUT = 1'h0;

  // Source engine.
  always_comb
  begin
    next_src = src_state;
    unique case (src_state)
      SRC_IDLE:
        if (src_start)
          next_src = SRC_SETTLE;
      SRC_SETTLE:
        if (settle_cnt == '0)
          next_src = SRC_RFD;
      SRC_RFD:
        if (s.nrfd && (rate_cnt == '0))
          next_src = SRC_DAC;
      SRC_DAC:
        if (s.ndac)
          next_src = SRC_GAP;
      SRC_GAP:
        next_src = SRC_IDLE;
    endcase
    if (!talker)
      next_src = SRC_IDLE;
  end

  assign TX_READY = (src_state == SRC_DAC) && s.ndac && talker;

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      src_state  <= SRC_IDLE;
      settle_cnt <= '0;
      rate_cnt   <= '0;
      tx_byte    <= 8'h00;
      DAV_OE     <= 1'h0;
      DIO_OE     <= 8'h00;
      SRC_ERROR  <= 1'h0;
    end
    else
    begin
      src_state <= next_src;
      settle_cnt <= (src_state == SRC_SETTLE) ? settle_cnt - 1'h1 : SETTLE_LAST;
      if (next_src == SRC_DAC && src_state == SRC_RFD)
        rate_cnt <= BYTE_LAST;
      else if (rate_cnt != '0)
        rate_cnt <= rate_cnt - 1'h1;
      if (src_start)
        tx_byte <= TX_DATA;
      DAV_OE <= (next_src == SRC_DAC);
      DIO_OE <= (next_src == SRC_SETTLE || next_src == SRC_RFD || next_src == SRC_DAC)
                ? (src_start ? TX_DATA : tx_byte) : 8'h00;
      if (src_state == SRC_IDLE && talker && TX_VALID)
        SRC_ERROR <= bus_error;
    end
  end

  // Acceptor engine.
  always_comb
  begin
    next_acc = acc_state;
    unique case (acc_state)
      ACC_OFF:
        next_acc = ACC_NOTRDY;
      ACC_NOTRDY:
        if (can_take)
          next_acc = ACC_READY;
      ACC_READY:
        if (dav_valid)
          next_acc = ACC_TAKE;
      ACC_TAKE:
        next_acc = ACC_DONE;
      ACC_DONE:
        if (!dav_valid)
          next_acc = ACC_NOTRDY;
    endcase
    if (!acc_active)
      next_acc = ACC_OFF;
  end

  // Not ready is released only while waiting for a byte, not accepted only after taking it.
  assign NRFD_OE = acc_active && (acc_state != ACC_OFF) && (acc_state != ACC_READY);
  assign NDAC_OE = acc_active && (acc_state != ACC_OFF) && (acc_state != ACC_DONE);

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      acc_state  <= ACC_OFF;
      cmd_strobe <= 1'h0;
      cmd_byte   <= 8'h00;
      RX_DATA    <= 8'h00;
      RX_VALID   <= 1'h0;
    end
    else
    begin
      acc_state  <= next_acc;
      cmd_strobe <= take_now && cmd_mode;
      if (take_now)
        cmd_byte <= ~s.dio;
      if (take_now && listener)
        RX_DATA <= ~s.dio;
      if (take_now && listener)
        RX_VALID <= 1'h1;
      else if (RX_READY)
        RX_VALID <= 1'h0;
    end
  end

  // Helper counters for the checks below.
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      data_age <= '0;
      dav_gap  <= '1;
    end
    else
    begin
      data_age <= (DIO_OE == 8'h00 && src_state != SRC_SETTLE) ? '0
                  : (data_age == '1 ? data_age : data_age + 1'h1);
      if (!DAV_OE && next_src == SRC_DAC)
        dav_gap <= '0;
      else if (dav_gap != '1)
        dav_gap <= dav_gap + 1'h1;
    end
  end

  AST_ERROR_BLOCKS: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (src_state == SRC_IDLE && talker && TX_VALID && bus_error) |=> src_state == SRC_IDLE)
    else $error("Source left idle while both ready lines were high.");

  AST_SETTLE_TIME: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    $rose(DAV_OE) |-> data_age >= SETTLE_MIN)
    else $error("Data valid asserted before the settle interval.");

  AST_VALID_NEEDS_READY: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    $rose(DAV_OE) |-> $past(s.nrfd) && $past(src_state) == SRC_RFD)
    else $error("Data valid asserted without ready sensed high.");

  AST_VALID_RELEASE: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    ($fell(DAV_OE) && $past(talker)) |-> $past(s.ndac) ##0 TX_READY == 1'h0)
    else $error("Data valid released before accepted went high.");

  AST_RATE_LIMIT: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (!DAV_OE && next_src == SRC_DAC) |-> dav_gap >= BYTE_MIN - 1'h1)
    else $error("Byte period shorter than one microsecond.");

  AST_ACCEPT_SEQUENCE: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (take_now && acc_active && !$changed(acc_active)) |=> NRFD_OE && NDAC_OE ##1
    (!acc_active || (NRFD_OE && !NDAC_OE)))
    else $error("Acceptor did not drop ready then release accepted.");

  AST_ACCEPTED_LOW: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (acc_state == ACC_DONE && !dav_valid && acc_active) |=> NDAC_OE || !acc_active)
    else $error("Accepted line not pulled low after valid rose.");

  AST_ACCEPTOR_START: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    $rose(acc_active) |=> (NRFD_OE && NDAC_OE) || !acc_active)
    else $error("Acceptor did not start with both lines low.");

  AST_TALKER_ONLY: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    !talker |=> !DAV_OE && DIO_OE == 8'h00)
    else $error("Bus driven as source while not talker.");

  AST_LISTENER_ONLY: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (!cmd_mode && !listener) |-> !NRFD_OE && !NDAC_OE)
    else $error("Acceptor lines held while not addressed to listen.");

endmodule // ibh_top

// *** include/ibh_consts.svh ***
// Timing counts, address field layout and reset values for the instrument bus handshake.
`ifndef IBH_CONSTS_SVH
`define IBH_CONSTS_SVH

`define IBH_CLK_PERIOD_NS 10
`define IBH_SETTLE_NS     200
`define IBH_MIN_BYTE_NS   1000
`define IBH_SETTLE_CYC    ((`IBH_SETTLE_NS + `IBH_CLK_PERIOD_NS - 1) / `IBH_CLK_PERIOD_NS)
`define IBH_BYTE_CYC      ((`IBH_MIN_BYTE_NS + `IBH_CLK_PERIOD_NS - 1) / `IBH_CLK_PERIOD_NS)

`define IBH_GRP_HI        6
`define IBH_GRP_LO        5
`define IBH_UNIT_HI       4
`define IBH_GRP_LISTEN    2'h1
`define IBH_GRP_TALK      2'h2
`define IBH_GRP_SECOND    2'h3
`define IBH_UNIT_NONE     5'h1F

`define IBH_LINE_IDLE     1'h1
`define IBH_CNT_W         16

`endif

// *** include/ibh_pkg.sv ***
// Types shared by the instrument bus handshake modules.
package ibh_pkg;

  typedef struct packed {
    logic       atn_n;
    logic       dav;
    logic       nrfd;
    logic       ndac;
    logic [7:0] dio;
  } ibh_lines_type;

  typedef enum logic [4:0] {
    SRC_IDLE   = 5'h01,
    SRC_SETTLE = 5'h02,
    SRC_RFD    = 5'h04,
    SRC_DAC    = 5'h08,
    SRC_GAP    = 5'h10
  } ibh_src_type;

  typedef enum logic [4:0] {
    ACC_OFF    = 5'h01,
    ACC_NOTRDY = 5'h02,
    ACC_READY  = 5'h04,
    ACC_TAKE   = 5'h08,
    ACC_DONE   = 5'h10
  } ibh_acc_type;

endpackage

// *** hdl/ibh_sync.sv ***
// Two-stage synchroniser for a vector of asynchronous bus lines.
`timescale 1ns/1ps
module ibh_sync
  import ibh_pkg::*;
#(
  parameter int unsigned W   = 12,
  parameter logic        RST = 1'h1
)
(
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rst,
  // Lines.
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  generate
    for (genvar i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          meta[i] <= RST;
          q[i]    <= RST;
        end
        else
        begin
          meta[i] <= d[i];
          q[i]    <= meta[i];
        end
      end
    end
  endgenerate

endmodule // ibh_sync

// *** hdl/ibh_addr.sv ***
// Listen and talk address recognition, with optional two-byte extended addressing.
`timescale 1ns/1ps
`include "ibh_consts.svh"
module ibh_addr
  import ibh_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst,
  // Command bytes taken in command mode.
  input  wire logic       cmd_strobe,
  input  wire logic [7:0] cmd_byte,
  // Own address setup.
  input  wire logic [4:0] my_addr,
  input  wire logic [4:0] my_sec,
  input  wire logic       ext_talk,
  input  wire logic       ext_listen,
  // Addressed state.
  output logic            talk_addr,
  output logic            listen_addr
);

  wire [1:0] grp       = cmd_byte[`IBH_GRP_HI:`IBH_GRP_LO];
  wire [4:0] unit      = cmd_byte[`IBH_UNIT_HI:0];
  wire       is_lsn    = cmd_strobe && (grp == `IBH_GRP_LISTEN);
  wire       is_tlk    = cmd_strobe && (grp == `IBH_GRP_TALK);
  wire       is_sec    = cmd_strobe && (grp == `IBH_GRP_SECOND);
  wire       unit_me   = (unit == my_addr);
  wire       sec_me    = is_sec && (unit == my_sec);
  wire       unlisten  = is_lsn && (unit == `IBH_UNIT_NONE);
  logic      pend_lsn;
  logic      pend_tlk;
  logic      next_talk;
  logic      next_listen;

  // Bit 7 is ignored; bits 6 and 5 pick listen or talk.
  always_comb
  begin
    next_listen = listen_addr;
    if (unlisten)
      next_listen = 1'h0;
    else if (is_lsn && unit_me && !ext_listen)
      next_listen = 1'h1;
    else if (pend_lsn && sec_me)
      next_listen = 1'h1;
  end

  always_comb
  begin
    next_talk = talk_addr;
    if (is_tlk && !(unit_me && ext_talk))
      next_talk = unit_me;
    else if (is_tlk)
      next_talk = 1'h0;
    else if (pend_tlk && is_sec)
      next_talk = sec_me;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      talk_addr   <= 1'h0;
      listen_addr <= 1'h0;
      pend_lsn    <= 1'h0;
      pend_tlk    <= 1'h0;
    end
    else
    begin
      talk_addr   <= next_talk;
      listen_addr <= next_listen;
      if (cmd_strobe)
      begin
        pend_lsn <= is_lsn && unit_me && ext_listen;
        pend_tlk <= is_tlk && unit_me && ext_talk;
      end
    end
  end

  AST_LISTEN_PRIMARY: assert property (@(posedge clk) disable iff (rst)
    (is_lsn && unit_me && !ext_listen && !unlisten) |=> listen_addr)
    else $error("Own listen address did not address the listener.");

  AST_TALK_TWO_BYTE: assert property (@(posedge clk) disable iff (rst)
    (is_tlk && unit_me && ext_talk) |=> !talk_addr ##0 pend_tlk)
    else $error("Extended talker was addressed by a single byte.");

  AST_LISTEN_TWO_BYTE: assert property (@(posedge clk) disable iff (rst)
    (pend_lsn && sec_me) |=> listen_addr)
    else $error("Matching secondary byte did not address the listener.");

endmodule // ibh_addr

// *** test/ibh_bus_model.sv ***
// Behavioural controller and fellow instruments on the shared handshake bus.
`timescale 1ns/1ps
module ibh_bus_model
(
  // Clock.
  input  wire logic       clk,
  // Device pull-downs.
  input  wire logic [7:0] dio_oe,
  input  wire logic       dav_oe,
  input  wire logic       nrfd_oe,
  input  wire logic       ndac_oe,
  // Resolved line levels.
  output logic      [7:0] dio,
  output logic            dav,
  output logic            nrfd,
  output logic            ndac,
  output logic            atn_n
);
  logic [7:0] m_dio  = 8'h00;
  logic       m_dav  = 1'h0;
  logic       m_nrfd = 1'h0;
  logic       m_ndac = 1'h0;

  initial
    atn_n = 1'h1;

  // Lines have pull-ups and sit low while any party pulls them.
  assign dio  = ~(dio_oe | m_dio);
  assign dav  = ~(dav_oe | m_dav);
  assign nrfd = ~(nrfd_oe | m_nrfd);
  assign ndac = ~(ndac_oe | m_ndac);

  function automatic logic level(input int w);
    return (w == 0) ? dav : ((w == 1) ? nrfd : ndac);
  endfunction

  task automatic wait_line(input int w, input logic lvl, inout logic ok);
    int k;
    k = 0;
    while (level(w) !== lvl && k < 3000)
    begin
      @(negedge clk);
      k++;
    end
    if (k >= 3000)
      ok = 1'h0;
  endtask

  task automatic set_atn(input logic lvl);
    @(negedge clk);
    atn_n = lvl;
    repeat (6) @(negedge clk);
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ok);
    ok = 1'h1;
    @(negedge clk);
    if (nrfd && ndac)
    begin
      ok = 1'h0;
      return;
    end
    m_dio = b;
    repeat (5) @(negedge clk);
    wait_line(1, 1'h1, ok);
    m_dav = 1'h1;
    wait_line(2, 1'h1, ok);
    m_dav = 1'h0;
    @(negedge clk);
    m_dio = 8'h00;
  endtask

  task automatic recv_byte(input int slow, output logic [7:0] b, output logic ok);
    ok = 1'h1;
    @(negedge clk);
    m_nrfd = 1'h1;
    m_ndac = 1'h1;
    repeat (slow) @(negedge clk);
    m_nrfd = 1'h0;
    wait_line(0, 1'h0, ok);
    m_nrfd = 1'h1;
    b = ~dio;
    repeat (slow) @(negedge clk);
    m_ndac = 1'h0;
    wait_line(0, 1'h1, ok);
    m_ndac = 1'h1;
  endtask

  task automatic idle_acc;
    @(negedge clk);
    m_nrfd = 1'h0;
    m_ndac = 1'h0;
  endtask
endmodule // ibh_bus_model

// *** test/tb.sv ***
// Self-checking bench for the instrument bus handshake port.
`timescale 1ns/1ps
module tb;
  localparam int SET = 4;
  localparam int BYT = 40;
  logic       core_clk = 1'h0;
  logic       sys_rst  = 1'h1;
  logic [7:0] dio_in, dio_oe, rx_data;
  logic       dav_in, dav_oe, nrfd_in, nrfd_oe, ndac_in, ndac_oe, atn_n;
  logic       tx_ready, rx_valid, talker, listener, src_error;
  logic [7:0] dio_out;
  logic       dav_out, nrfd_out, ndac_out;
  logic [4:0] my_addr, my_sec;
  logic       ext_talk, ext_listen;
  logic [7:0] tx_data;
  logic       tx_valid, rx_ready;
  int         miscompares = 0;
  int         cmp_count   = 0;
  int         cyc = 0, t_oe = 0, t_dav = 0, min_set = 9999, min_gap = 9999;
  logic [7:0] oe_prev   = 8'h00;
  logic       dav_prev  = 1'h0, nrfd_prev = 1'h1, early_dav = 1'h0, acc_init = 1'h0;

  ibh_top #(
    .SETTLE_CYC (SET),
    .BYTE_CYC   (BYT)
  ) u_ibh_top (
    .CORE_CLK   (core_clk),
    .SYS_RST    (sys_rst),
    .DIO_IN     (dio_in),
    .DIO_OUT    (dio_out),
    .DIO_OE     (dio_oe),
    .DAV_IN     (dav_in),
    .DAV_OUT    (dav_out),
    .DAV_OE     (dav_oe),
    .NRFD_IN    (nrfd_in),
    .NRFD_OUT   (nrfd_out),
    .NRFD_OE    (nrfd_oe),
    .NDAC_IN    (ndac_in),
    .NDAC_OUT   (ndac_out),
    .NDAC_OE    (ndac_oe),
    .ATN_N      (atn_n),
    .MY_ADDR    (my_addr),
    .MY_SEC     (my_sec),
    .EXT_TALK   (ext_talk),
    .EXT_LISTEN (ext_listen),
    .TX_DATA    (tx_data),
    .TX_VALID   (tx_valid),
    .TX_READY   (tx_ready),
    .RX_DATA    (rx_data),
    .RX_VALID   (rx_valid),
    .RX_READY   (rx_ready),
    .TALKER     (talker),
    .LISTENER   (listener),
    .SRC_ERROR  (src_error)
  );

  ibh_bus_model u_ibh_bus_model (
    .clk     (core_clk),
    .dio_oe  (dio_oe),
    .dav_oe  (dav_oe),
    .nrfd_oe (nrfd_oe),
    .ndac_oe (ndac_oe),
    .dio     (dio_in),
    .dav     (dav_in),
    .nrfd    (nrfd_in),
    .ndac    (ndac_in),
    .atn_n   (atn_n)
  );

  initial
    forever #5 core_clk = ~core_clk;

  // Tracks settle time, byte spacing and valid-before-ready of the device as source.
  always @(negedge core_clk)
  begin
    cyc++;
    if (nrfd_oe === 1'h1 && ndac_oe === 1'h1 && dav_in === 1'h1)
      acc_init = 1'h1;
    if (dio_oe !== 8'h00 && oe_prev === 8'h00)
      t_oe = cyc;
    if (dav_oe === 1'h1 && dav_prev === 1'h0)
    begin
      min_set = (cyc - t_oe < min_set) ? cyc - t_oe : min_set;
      min_gap = (t_dav > 0 && cyc - t_dav < min_gap) ? cyc - t_dav : min_gap;
      early_dav = early_dav | ~nrfd_prev;
      t_dav = cyc;
    end
    oe_prev = dio_oe;
    dav_prev = dav_oe;
    nrfd_prev = nrfd_in;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic cmd(input logic [7:0] b);
    logic ok;
    u_ibh_bus_model.set_atn(1'h0);
    u_ibh_bus_model.send_byte(b, ok);
    chk("cmd handshake", 8'h01, {7'h00, ok});
  endtask

  task automatic wait_ready;
    int k;
    k = 0;
    @(negedge core_clk);
    while (tx_ready !== 1'h1 && k < 3000)
    begin
      @(negedge core_clk);
      k++;
    end
    chk("tx_ready", 8'h01, {7'h00, tx_ready});
  endtask

  task automatic t_reset;
    chk("dio_oe", 8'h00, dio_oe);
    chk("roles", 8'h00, {4'h0, dav_oe, talker, listener, src_error});
    chk("pull data", 8'h00, dio_out);
    chk("pull lines", 8'h00, {5'h00, dav_out, nrfd_out, ndac_out});
    u_ibh_bus_model.set_atn(1'h0);
    chk("acc init", 8'h01, {7'h00, acc_init});
    chk("acc ready", 8'h01, {6'h00, nrfd_oe, ndac_oe});
  endtask

  task automatic t_listen;
    logic ok;
    cmd({3'h1, my_addr});
    chk("listener cmd", 8'h00, {7'h00, listener});
    u_ibh_bus_model.set_atn(1'h1);
    chk("listener", 8'h01, {7'h00, listener});
    u_ibh_bus_model.send_byte(8'hA5, ok);
    chk("data handshake", 8'h01, {7'h00, ok});
    chk("rx_data", 8'hA5, rx_data);
    chk("rx_valid", 8'h01, {7'h00, rx_valid});
    repeat (4) @(negedge core_clk);
    chk("held not ready", 8'h03, {6'h00, nrfd_oe, ndac_oe});
    chk("dav_oe", 8'h00, {7'h00, dav_oe});
    rx_ready = 1'h1;
    @(negedge core_clk);
    rx_ready = 1'h0;
    repeat (4) @(negedge core_clk);
    chk("ready again", 8'h01, {6'h00, nrfd_oe, ndac_oe});
    cmd(8'h3F);
    u_ibh_bus_model.set_atn(1'h1);
    chk("unlisten", 8'h00, {7'h00, listener});
  endtask

  task automatic t_talk;
    logic [7:0] b1, b2;
    logic       ok1, ok2;
    cmd({3'h2, my_addr});
    u_ibh_bus_model.set_atn(1'h1);
    chk("talker", 8'h01, {7'h00, talker});
    fork
      begin
        u_ibh_bus_model.recv_byte(20, b1, ok1);
        u_ibh_bus_model.recv_byte(0, b2, ok2);
      end
      begin
        repeat (2) @(negedge core_clk);
        tx_data = 8'h3C;
        tx_valid = 1'h1;
        wait_ready();
        tx_data = 8'hC3;
        wait_ready();
        tx_valid = 1'h0;
      end
    join
    chk("byte 1", 8'h3C, b1);
    chk("byte 2", 8'hC3, b2);
    chk("acc handshakes", 8'h03, {6'h00, ok1, ok2});
    chk("settle", 8'h01, {7'h00, min_set >= SET});
    chk("byte spacing", 8'h01, {7'h00, min_gap >= BYT});
    chk("early valid", 8'h00, {7'h00, early_dav});
  endtask

  task automatic t_error;
    u_ibh_bus_model.idle_acc();
    repeat (4) @(negedge core_clk);
    tx_valid = 1'h1;
    repeat (6) @(negedge core_clk);
    chk("src_error", 8'h01, {7'h00, src_error});
    chk("dio_oe on error", 8'h00, dio_oe);
    tx_valid = 1'h0;
    u_ibh_bus_model.set_atn(1'h0);
    chk("talker cmd", 8'h00, {7'h00, talker});
    cmd(8'h5F);
  endtask

  task automatic t_ext;
    ext_talk = 1'h1;
    ext_listen = 1'h1;
    my_addr = 5'h04;
    my_sec = 5'h0E;
    cmd({3'h1, my_addr});
    u_ibh_bus_model.set_atn(1'h1);
    chk("primary only", 8'h00, {7'h00, listener});
    cmd({3'h1, my_addr});
    cmd({3'h3, my_sec});
    u_ibh_bus_model.set_atn(1'h1);
    chk("ext listener", 8'h01, {7'h00, listener});
    cmd({3'h2, my_addr});
    cmd({3'h3, my_sec ^ 5'h01});
    u_ibh_bus_model.set_atn(1'h1);
    chk("bad secondary", 8'h00, {7'h00, talker});
    cmd({3'h2, my_addr});
    cmd({3'h3, my_sec});
    u_ibh_bus_model.set_atn(1'h1);
    chk("ext talker", 8'h01, {7'h00, talker});
  endtask

  initial
  begin
    my_addr    = 5'h0B;
    my_sec     = 5'h13;
    ext_talk   = 1'h0;
    ext_listen = 1'h0;
    tx_data    = 8'h00;
    tx_valid   = 1'h0;
    rx_ready   = 1'h0;
    repeat (2) @(negedge core_clk);
    sys_rst = 1'h0;
    t_reset();
    t_listen();
    t_talk();
    t_error();
    t_ext();
    finish_test();
  end

  initial
  begin
    #400000;
    miscompares++;
    finish_test();
  end
endmodule // tb
